//--- serial_ctl_pkg.sv
// Shared constants and types for the serial format and control block.
package serial_ctl_pkg;

  // Register byte addresses on the APB.
  localparam logic [7:0] ADDR_FORMAT  = 8'h00;
  localparam logic [7:0] ADDR_BITRATE = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_TXDATA  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS  = 8'h10;
  localparam logic [7:0] ADDR_RXDATA  = 8'h14;

  // Reset values of the registers.
  localparam logic [7:0] FORMAT_RST  = 8'h00;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] BITRATE_RST = 8'hff;
  localparam logic [7:0] TXDATA_RST  = 8'hff;
  localparam logic [7:0] RXDATA_RST  = 8'h00;
  localparam logic [7:0] STATUS_RST  = 8'h84;

  // Status bits that software may clear, and positions that clear together.
  localparam logic [7:0] STATUS_CLR_MASK = 8'hfd;
  localparam int         ST_TX_EMPTY     = 7;
  localparam int         ST_TX_END       = 2;

  // Prescaler terminal counts for phi, phi/4, phi/16 and phi/64.
  localparam logic [5:0] PRESC_LAST_1  = 6'h00;
  localparam logic [5:0] PRESC_LAST_4  = 6'h03;
  localparam logic [5:0] PRESC_LAST_16 = 6'h0f;
  localparam logic [5:0] PRESC_LAST_64 = 6'h3f;

  // Sixteen sample ticks make one asynchronous bit time.
  localparam logic [3:0] PHASE_LAST = 4'hf;
  localparam logic [3:0] PHASE_MID  = 4'h7;

  // Character lengths in bits.
  localparam logic [3:0] LEN_8 = 4'h8;
  localparam logic [3:0] LEN_7 = 4'h7;

  // Frame format register layout.
  typedef struct packed {
    logic       syncMode;
    logic       charLenSel;
    logic       parityEn;
    logic       parityOdd;
    logic       twoStop;
    logic       multiprocFmt;
    logic [1:0] prescaleSel;
  } format_t;

  // Enable and control register layout.
  typedef struct packed {
    logic       txEmptyIrqEn;
    logic       rxIrqEn;
    logic       txEn;
    logic       rxEn;
    logic       multiprocIrqEn;
    logic       txEndIrqEn;
    logic [1:0] clkEnable;
  } control_t;

  // Status register layout.
  typedef struct packed {
    logic txEmptyFlag;
    logic rxFullFlag;
    logic overrunErrFlag;
    logic framingErrFlag;
    logic parityErrFlag;
    logic txEnd;
    logic multiprocRxBit;
    logic multiprocTxBit;
  } status_t;

  // One received character as handed from the receiver.
  typedef struct packed {
    logic       done;
    logic [7:0] data;
    logic       parityErr;
    logic       frameErr;
    logic       mpBit;
  } rx_result_t;

  // Receiver states, Gray coded along the frame.
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } rx_state_t;

endpackage

//--- serial_baud_gen.sv
// Prescaler and bit rate counter that produce the oversampling tick.
`timescale 1ns/1ps
`default_nettype none
module serial_baud_gen #(
  parameter int RATE_W = 8
) (
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst_b,
  // Rate selection.
  input  wire logic [1:0]        prescaleSel,
  input  wire logic [RATE_W-1:0] bitRate,
  // One-cycle tick at sixteen times the asynchronous bit rate.
  output logic                   sampleTick
);

  typedef struct packed {
    logic [5:0]        presc;
    logic [RATE_W-1:0] rate;
    logic              tick;
  } baud_state_t;

  baud_state_t s_r;
  baud_state_t s_nxt;
  logic [5:0]  prescLast;

  if (RATE_W < 1) begin : gChk
    $error("RATE_W must be at least one");
  end

  // Prescale, then divide by bitRate plus one.
  always_comb
  begin
    case (prescaleSel)
      2'b00:   prescLast = serial_ctl_pkg::PRESC_LAST_1;
      2'b01:   prescLast = serial_ctl_pkg::PRESC_LAST_4;
      2'b10:   prescLast = serial_ctl_pkg::PRESC_LAST_16;
      default: prescLast = serial_ctl_pkg::PRESC_LAST_64;
    endcase
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (s_r.presc >= prescLast) // [RQ9]
    begin
      s_nxt.presc = '0;
      if (s_r.rate >= bitRate)
      begin
        s_nxt.rate = '0;
        s_nxt.tick = 1'b1;
      end
      else
        s_nxt.rate = s_r.rate + 1'b1;
    end
    else
      s_nxt.presc = s_r.presc + 6'h01;
  end

  // State register.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign sampleTick = s_r.tick;

endmodule
`default_nettype wire

//--- serial_receiver.sv
// Receive framer for asynchronous and clocked synchronous characters.
`timescale 1ns/1ps
`default_nettype none
module serial_receiver (
  // Clock and reset.
  input  wire logic                       clock,
  input  wire logic                       rst_b,
  // Configuration.
  input  wire serial_ctl_pkg::format_t    fmt,
  input  wire logic                       rxEn,
  // Line events, already synchronised.
  input  wire logic                       rxd,
  input  wire logic                       sckRise,
  input  wire logic                       sampleTick,
  // Finished character.
  output serial_ctl_pkg::rx_result_t      result
);

  typedef struct packed {
    serial_ctl_pkg::rx_state_t  state;
    logic [3:0]                 phase;
    logic [3:0]                 bitCnt;
    logic [8:0]                 shift;
    serial_ctl_pkg::rx_result_t res;
  } rx_reg_t;

  rx_reg_t    s_r;
  rx_reg_t    s_nxt;
  logic [3:0] dataLen;
  logic [3:0] total;
  logic       hasExtra;
  logic       finish;
  logic [7:0] dataBits;

  // Walk the frame; a second stop bit is never looked at, so a low one restarts.
  always_comb
  begin
    s_nxt          = s_r;
    s_nxt.res.done = 1'b0;
    finish         = 1'b0;
    dataLen  = (!fmt.syncMode && fmt.charLenSel) ? serial_ctl_pkg::LEN_7
                                                 : serial_ctl_pkg::LEN_8; // [RQ2]
    hasExtra = !fmt.syncMode && (fmt.parityEn || fmt.multiprocFmt); // [RQ4] [RQ8]
    total    = dataLen + {3'b000, hasExtra};
    case (s_r.state)
      serial_ctl_pkg::RX_IDLE:
      begin
        s_nxt.phase  = '0;
        s_nxt.bitCnt = '0;
        if (fmt.syncMode && sckRise) // [RQ19]
        begin
          s_nxt.shift[0] = rxd;
          s_nxt.bitCnt   = 4'h1;
          s_nxt.state    = serial_ctl_pkg::RX_DATA;
        end
        else if (!fmt.syncMode && sampleTick && !rxd) // [RQ19]
          s_nxt.state = serial_ctl_pkg::RX_START;
      end
      serial_ctl_pkg::RX_START:
        if (sampleTick)
        begin
          s_nxt.phase = s_r.phase + 4'h1;
          if (s_r.phase == serial_ctl_pkg::PHASE_MID)
          begin
            s_nxt.phase = '0;
            s_nxt.state = rxd ? serial_ctl_pkg::RX_IDLE : serial_ctl_pkg::RX_DATA;
          end
        end
      serial_ctl_pkg::RX_DATA:
        if (fmt.syncMode)
        begin
          if (sckRise)
          begin
            s_nxt.shift[s_r.bitCnt] = rxd;
            s_nxt.bitCnt            = s_r.bitCnt + 4'h1;
            if (s_nxt.bitCnt == serial_ctl_pkg::LEN_8)
            begin
              finish      = 1'b1;
              s_nxt.state = serial_ctl_pkg::RX_IDLE;
            end
          end
        end
        else if (sampleTick)
        begin
          s_nxt.phase = s_r.phase + 4'h1;
          if (s_r.phase == serial_ctl_pkg::PHASE_LAST)
          begin
            s_nxt.shift[s_r.bitCnt] = rxd;
            s_nxt.bitCnt            = s_r.bitCnt + 4'h1;
            if (s_nxt.bitCnt == total)
              s_nxt.state = serial_ctl_pkg::RX_STOP;
          end
        end
      serial_ctl_pkg::RX_STOP:
        if (sampleTick)
        begin
          s_nxt.phase = s_r.phase + 4'h1;
          if (s_r.phase == serial_ctl_pkg::PHASE_LAST) // [RQ7]
          begin
            finish      = 1'b1;
            s_nxt.state = serial_ctl_pkg::RX_IDLE;
          end
        end
      default:
        s_nxt.state = serial_ctl_pkg::RX_IDLE;
    endcase
    // Hand over the character with its checks.
    dataBits = (dataLen == serial_ctl_pkg::LEN_7) ? {1'b0, s_nxt.shift[6:0]}
                                                  : s_nxt.shift[7:0];
    if (finish)
    begin
      s_nxt.res.done      = 1'b1;
      s_nxt.res.data      = dataBits;
      s_nxt.res.mpBit     = s_nxt.shift[dataLen];
      s_nxt.res.frameErr  = !fmt.syncMode && !rxd;
      s_nxt.res.parityErr = hasExtra && !fmt.multiprocFmt &&
                            ((^dataBits ^ s_nxt.shift[dataLen]) != fmt.parityOdd); // [RQ5]
    end
    if (!rxEn)
      s_nxt.state = serial_ctl_pkg::RX_IDLE;
  end

  // State register.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign result = s_r.res;

endmodule
`default_nettype wire

//--- serial_format_ctl.sv
// Serial channel with format, enable and status registers behind APB.
`timescale 1ns/1ps
`default_nettype none
// Function
// (RQ1) Format top bit picks asynchronous or synchronous.
// (RQ2) Async length bit: 8 or 7; sync 8.
// (RQ3) Seven-bit characters drop transmit bit 7.
// (RQ4) Async parity enable adds and checks parity.
// (RQ5) Parity select: even or odd ones count.
// (RQ6) Async stop select: one or two stops.
// (RQ7) Receiver checks only the first stop bit.
// (RQ8) Multiprocessor format overrides parity, async only.
// (RQ9) Prescaler picks phi, /4, /16 or /64.
// (RQ10) Both registers clear on reset and standby.
// (RQ11) Transmit-empty interrupt when holding register moves.
// (RQ12) Read-one-then-write-zero or disable withdraws it.
// (RQ13) Receive enable gates full and error interrupts.
// (RQ14) Clearing receive flags withdraws receive interrupts.
// (RQ15) Transmit disabled holds transmit-empty at one.
// (RQ16) Send after data write and flag clear.
// (RQ17) Software sets format before enabling.
// (RQ18) Receive disable leaves receive flags untouched.
// (RQ19) Receive starts on start bit or clock.
// (RQ20) Multiprocessor interrupt enable needs async multiprocessor format.
// (RQ21) Skip characters until multiprocessor bit one.
// (RQ22) No holding-register move while transmit-empty set.
// (RQ23) Async frame: start, data, extra bit, stops.
module serial_format_ctl #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input  wire logic              clock,
  input  wire logic              rst_b,
  // Power control.
  input  wire logic              standby,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Serial pins.
  input  wire logic              rxdPin,
  input  wire logic              sckPin,
  output logic                   txdPin,
  // Interrupt requests.
  output logic                   txEmptyIrq,
  output logic                   rxFullIrq,
  output logic                   rxErrIrq,
  output logic                   txEndIrq
);

  typedef struct packed {
    serial_ctl_pkg::format_t  fmt;
    serial_ctl_pkg::control_t ctl;
    logic [7:0]               bitRate;
    logic [7:0]               txHold;
    logic [7:0]               rxData;
    serial_ctl_pkg::status_t  st;
    logic [7:0]               seen;
    logic [11:0]              txShift;
    logic [3:0]               txBits;
    logic [3:0]               txPhase;
    logic                     txd;
    logic [31:0]              rdata;
    logic [3:0]               irq;
    logic                     rxdMeta;
    logic                     rxdSync;
    logic                     sckMeta;
    logic                     sckSync;
    logic                     sckPrev;
  } ctl_state_t;

  localparam ctl_state_t RESET_STATE = '{
    fmt:     serial_ctl_pkg::FORMAT_RST,
    ctl:     serial_ctl_pkg::CONTROL_RST,
    bitRate: serial_ctl_pkg::BITRATE_RST,
    txHold:  serial_ctl_pkg::TXDATA_RST,
    rxData:  serial_ctl_pkg::RXDATA_RST,
    st:      serial_ctl_pkg::STATUS_RST,
    txShift: '1,
    txd:     1'b1,
    rxdMeta: 1'b1,
    rxdSync: 1'b1,
    default: '0
  };

  ctl_state_t                 s_r;
  ctl_state_t                 s_nxt;
  serial_ctl_pkg::rx_result_t rxRes;
  logic                       sampleTick;
  logic                       sckRise;
  logic                       sckFall;
  logic                       setupPh;
  logic                       wrAcc;
  logic                       rdAcc;
  logic                       mapped;
  logic [7:0]                 addr8;
  logic [7:0]                 clr;
  logic [7:0]                 txData;
  logic [3:0]                 txLen;
  logic                       txExtra;
  logic                       txExtraBit;
  logic                       mpSkip;

  if (ADDR_W < 5) begin : gChk
    $error("ADDR_W too narrow for the register map");
  end

  // Baud rate generator.
  serial_baud_gen #(
    .RATE_W (8)
  ) uBaud (
    .clock       (clock),
    .rst_b       (rst_b),
    .prescaleSel (s_r.fmt.prescaleSel),
    .bitRate     (s_r.bitRate),
    .sampleTick  (sampleTick)
  );

  // Receive framer.
  serial_receiver uRx (
    .clock      (clock),
    .rst_b      (rst_b),
    .fmt        (s_r.fmt),
    .rxEn       (s_r.ctl.rxEn),
    .rxd        (s_r.rxdSync),
    .sckRise    (sckRise),
    .sampleTick (sampleTick),
    .result     (rxRes)
  );

  // Clock edges in synchronous mode and the APB phase decode.
  assign sckRise = s_r.fmt.syncMode && s_r.sckSync && !s_r.sckPrev; // [RQ1]
  assign sckFall = s_r.fmt.syncMode && !s_r.sckSync && s_r.sckPrev; // [RQ1]
  assign setupPh = psel && !penable;
  assign wrAcc   = psel && penable && pwrite;
  assign rdAcc   = psel && penable && !pwrite;
  assign addr8   = 8'(paddr);
  assign mapped  = (ADDR_W <= 8 || (paddr >> 8) == '0) &&
                   (addr8 == serial_ctl_pkg::ADDR_FORMAT  ||
                    addr8 == serial_ctl_pkg::ADDR_BITRATE ||
                    addr8 == serial_ctl_pkg::ADDR_CONTROL ||
                    addr8 == serial_ctl_pkg::ADDR_TXDATA  ||
                    addr8 == serial_ctl_pkg::ADDR_STATUS  ||
                    addr8 == serial_ctl_pkg::ADDR_RXDATA);

  // Frame pieces for the next character to send.
  assign txLen      = (!s_r.fmt.syncMode && s_r.fmt.charLenSel) ? serial_ctl_pkg::LEN_7
                                                                : serial_ctl_pkg::LEN_8;
  assign txData     = (txLen == serial_ctl_pkg::LEN_7) ? {1'b0, s_r.txHold[6:0]}
                                                       : s_r.txHold; // [RQ3]
  assign txExtra    = !s_r.fmt.syncMode && (s_r.fmt.parityEn || s_r.fmt.multiprocFmt);
  assign txExtraBit = s_r.fmt.multiprocFmt ? s_r.st.multiprocTxBit
                                           : (^txData ^ s_r.fmt.parityOdd); // [RQ5] [RQ8]
  assign mpSkip     = s_r.ctl.multiprocIrqEn && s_r.fmt.multiprocFmt &&
                      !s_r.fmt.syncMode; // [RQ20]

  // Next-state logic: bus access, transmitter, receive flags and requests.
  always_comb
  begin
    s_nxt         = s_r;
    clr           = '0;
    s_nxt.rxdMeta = rxdPin;
    s_nxt.rxdSync = s_r.rxdMeta;
    s_nxt.sckMeta = sckPin;
    s_nxt.sckSync = s_r.sckMeta;
    s_nxt.sckPrev = s_r.sckSync;

    // Read data is prepared in the setup phase and held through access.
    if (setupPh)
    begin
      case (addr8)
        serial_ctl_pkg::ADDR_FORMAT:  s_nxt.rdata = {24'h000000, s_r.fmt};
        serial_ctl_pkg::ADDR_BITRATE: s_nxt.rdata = {24'h000000, s_r.bitRate};
        serial_ctl_pkg::ADDR_CONTROL: s_nxt.rdata = {24'h000000, s_r.ctl};
        serial_ctl_pkg::ADDR_TXDATA:  s_nxt.rdata = {24'h000000, s_r.txHold};
        serial_ctl_pkg::ADDR_STATUS:  s_nxt.rdata = {24'h000000, s_r.st};
        serial_ctl_pkg::ADDR_RXDATA:  s_nxt.rdata = {24'h000000, s_r.rxData};
        default:                      s_nxt.rdata = '0;
      endcase
    end

    // A status read arms the flags that software saw as one.
    if (rdAcc && mapped && addr8 == serial_ctl_pkg::ADDR_STATUS)
      s_nxt.seen = s_r.seen | s_r.rdata[7:0]; // [RQ12] [RQ14]

    // Register writes; status bits clear only once armed by a read.
    if (wrAcc && mapped)
    begin
      case (addr8)
        serial_ctl_pkg::ADDR_FORMAT:  s_nxt.fmt     = pwdata[7:0]; // [RQ10]
        serial_ctl_pkg::ADDR_BITRATE: s_nxt.bitRate = pwdata[7:0];
        serial_ctl_pkg::ADDR_CONTROL: s_nxt.ctl     = pwdata[7:0]; // [RQ10]
        serial_ctl_pkg::ADDR_TXDATA:  s_nxt.txHold  = pwdata[7:0];
        serial_ctl_pkg::ADDR_STATUS:
        begin
          clr = s_r.seen & ~pwdata[7:0] & serial_ctl_pkg::STATUS_CLR_MASK; // [RQ12] [RQ14]
          clr[serial_ctl_pkg::ST_TX_END] = clr[serial_ctl_pkg::ST_TX_EMPTY];
          s_nxt.st.multiprocTxBit = pwdata[0];
        end
        default:
        begin
        end
      endcase
    end
    s_nxt.st   = s_nxt.st & ~clr;
    s_nxt.seen = s_nxt.seen & ~clr;

    // Load the shifter once software has cleared the flag.
    if (s_r.ctl.txEn && !s_r.st.txEmptyFlag && s_r.txBits == '0) // [RQ16] [RQ22]
    begin
      s_nxt.st.txEmptyFlag = 1'b1; // [RQ11]
      s_nxt.st.txEnd       = 1'b0;
      s_nxt.txPhase        = '0;
      s_nxt.txShift        = '1;
      if (s_r.fmt.syncMode)
      begin
        s_nxt.txShift[7:0] = s_r.txHold;
        s_nxt.txBits       = serial_ctl_pkg::LEN_8; // [RQ6]
      end
      else
      begin
        s_nxt.txShift[0] = 1'b0; // [RQ23]
        for (int i = 0; i < 8; i++)
        begin
          if (i < int'(txLen))
            s_nxt.txShift[i + 1] = txData[i];
        end
        if (txExtra)
          s_nxt.txShift[txLen + 4'h1] = txExtraBit; // [RQ4] [RQ23]
        s_nxt.txBits = 4'h2 + txLen + {3'b000, txExtra} + {3'b000, s_r.fmt.twoStop}; // [RQ6]
      end
    end
    // Shift one bit per bit time, or per falling serial clock edge.
    else if (s_r.txBits != '0)
    begin
      if (s_r.fmt.syncMode ? sckFall : sampleTick)
      begin
        s_nxt.txPhase = s_r.txPhase + 4'h1;
        if (s_r.fmt.syncMode || s_r.txPhase == serial_ctl_pkg::PHASE_LAST)
        begin
          s_nxt.txShift = {1'b1, s_r.txShift[11:1]};
          s_nxt.txBits  = s_r.txBits - 4'h1;
          if (s_r.txBits == 4'h1 && s_nxt.st.txEmptyFlag)
            s_nxt.st.txEnd = 1'b1;
        end
      end
    end
    if (!s_r.ctl.txEn)
    begin
      s_nxt.txBits         = '0;
      s_nxt.st.txEmptyFlag = 1'b1; // [RQ15]
    end
    s_nxt.txd = (s_nxt.txBits == '0) ? 1'b1 : s_nxt.txShift[0];

    // Received characters set flags after any clear in the same cycle.
    if (rxRes.done && s_r.ctl.rxEn) // [RQ18]
    begin
      if (s_r.fmt.multiprocFmt && !s_r.fmt.syncMode)
        s_nxt.st.multiprocRxBit = rxRes.mpBit;
      if (!mpSkip || rxRes.mpBit) // [RQ21]
      begin
        if (mpSkip)
          s_nxt.ctl.multiprocIrqEn = 1'b0; // [RQ21]
        if (s_r.st.rxFullFlag)
          s_nxt.st.overrunErrFlag = 1'b1;
        else if (rxRes.frameErr || rxRes.parityErr)
        begin
          s_nxt.st.framingErrFlag = s_nxt.st.framingErrFlag | rxRes.frameErr;
          s_nxt.st.parityErrFlag  = s_nxt.st.parityErrFlag | rxRes.parityErr; // [RQ4]
        end
        else
        begin
          s_nxt.st.rxFullFlag = 1'b1;
          s_nxt.rxData        = rxRes.data;
        end
      end
    end

    // Interrupt requests follow flags and enables.
    s_nxt.irq[3] = s_nxt.ctl.txEmptyIrqEn && s_nxt.st.txEmptyFlag; // [RQ11] [RQ12]
    s_nxt.irq[2] = s_nxt.ctl.rxIrqEn && s_nxt.st.rxFullFlag; // [RQ13] [RQ14]
    s_nxt.irq[1] = s_nxt.ctl.rxIrqEn && (s_nxt.st.overrunErrFlag ||
                   s_nxt.st.framingErrFlag || s_nxt.st.parityErrFlag); // [RQ13] [RQ14]
    s_nxt.irq[0] = s_nxt.ctl.txEndIrqEn && s_nxt.st.txEnd;

    // Standby returns every register of this block to its reset value; uBaud and uRx keep their state.
    if (standby)
      s_nxt = RESET_STATE; // [RQ10]
  end

  // State register.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= RESET_STATE; // [RQ10]
    else
      s_r <= s_nxt;
  end

  // Outputs.
  assign prdata     = s_r.rdata;
  assign pready     = psel && penable;
  assign pslverr    = psel && penable && !mapped;
  assign txdPin     = s_r.txd;
  assign txEmptyIrq = s_r.irq[3];
  assign rxFullIrq  = s_r.irq[2];
  assign rxErrIrq   = s_r.irq[1];
  assign txEndIrq   = s_r.irq[0];

endmodule
`default_nettype wire

//--- serial_format_ctl_chk.sv
// Bus, register and interrupt checks of the serial channel.
`timescale 1ns/1ps
`default_nettype none
module serial_format_ctl_chk #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic              clock,
  input wire logic              rst_b,
  // Watched inputs.
  input wire logic              standby,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  // Watched outputs.
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              txdPin,
  input wire logic              txEmptyIrq,
  input wire logic              rxFullIrq,
  input wire logic              rxErrIrq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic       acc;
  logic       ctlWr;
  logic [7:0] fmtVal;
  logic [7:0] ctlVal;
  // Access edges, and control writes at them.
  assign acc   = psel && penable;
  assign ctlWr = acc && pwrite && paddr == 8'h08;
  // Last values written, cleared like the registers.
  always_ff @(posedge clock)
  begin
    if (!rst_b || standby)
    begin
      fmtVal <= 8'h00;
      ctlVal <= 8'h00;
    end
    else if (acc && pwrite && paddr == 8'h00)
      fmtVal <= pwdata[7:0];
    else if (ctlWr)
      ctlVal <= pwdata[7:0];
  end
  bus_ready_a: assert property (acc |-> pready && prdata[31:8] == 24'h0)
    else $error("Bad bus answer");
  unmapped_err_a: assert property (acc && paddr == 8'h20 |-> pslverr)
    else $error("No slave error");
  fmt_readback_a: assert property (acc && !pwrite && paddr == 8'h00 |-> prdata[7:0] == fmtVal)
    else $error("Format read differs");
  ctl_readback_a: assert property (acc && !pwrite && paddr == 8'h08 |->
    (prdata[7:0] & 8'hf7) == (ctlVal & 8'hf7)) else $error("Control read differs");
  standby_clear_a: assert property (standby |=> !txEmptyIrq && !rxFullIrq && !rxErrIrq && txdPin)
    else $error("Standby left state");
  tx_irq_off_a: assert property (ctlWr && !pwdata[7] |-> ##2 !txEmptyIrq)
    else $error("Tx irq stays");
  rx_irq_off_a: assert property (ctlWr && !pwdata[6] |->
    ##2 !rxFullIrq && !rxErrIrq) else $error("Rx irq stays");
  tx_held_empty_a: assert property (ctlWr && pwdata[7:5] == 3'b100
    |-> ##2 txEmptyIrq) else $error("Empty flag not held");
endmodule
bind serial_format_ctl serial_format_ctl_chk #(.ADDR_W(ADDR_W)) i_chk (.clock, .rst_b, .standby,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .txdPin, .txEmptyIrq,
  .rxFullIrq, .rxErrIrq);
`default_nettype wire

//--- serial_peer.sv
// Remote asynchronous peer that captures and sends frames.
`timescale 1ns/1ps
`default_nettype none
module serial_peer #(
  parameter int BIT = 16
) (
  // Clock.
  input  wire logic   clock,
  // Lines.
  input  wire logic   txd,
  output logic        rxd,
  output logic [11:0] frame
);
  // Capture twelve bits mid-bit after each start edge.
  initial
  begin
    rxd = 1'b1;
    frame = 12'h000;
    forever
    begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge clock);
      for (int i = 0; i < 12; i++)
      begin
        frame[i] = txd;
        repeat (BIT) @(posedge clock);
      end
    end
  end
  // Send twelve bits, start bit first.
  task automatic send(input logic [11:0] bits);
    for (int i = 0; i < 12; i++)
    begin
      rxd <= bits[i];
      repeat (BIT) @(posedge clock);
    end
  endtask
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench of the serial channel registers and frames.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock, rst_b, standby, psel, penable, pwrite, pready, pslverr;
  logic        txd, rxd, txEmptyIrq, rxFullIrq, rxErrIrq, txEndIrq;
  logic [7:0]  paddr;
  logic [11:0] q, frame;
  logic [31:0] pwdata, prdata;
  int          bad_count, total_checks, cycles, n;
  serial_format_ctl i_dut (.clock, .rst_b, .standby, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .rxdPin(rxd), .sckPin(1'b0), .txdPin(txd),
    .txEmptyIrq, .rxFullIrq, .rxErrIrq, .txEndIrq);
  serial_peer i_peer (.clock, .txd, .rxd, .frame);
  // Clock and cycle watchdog.
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      bad_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // One bus transfer; q holds the error bit above the read byte.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    q = {3'h0, pslverr, prdata[7:0]};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  function automatic logic [11:0] frm(input logic [7:0] f, input logic [7:0] d);
    logic [11:0] e;
    logic        p;
    int          len;
    len = f[6] ? 7 : 8;
    e = 12'hffe;
    p = f[4];
    for (int i = 0; i < len; i++)
    begin
      e[i + 1] = d[i];
      p ^= d[i];
    end
    if (!f[2] && f[5])
      e[len + 1] = p;
    return e;
  endfunction
  task automatic send_char(input logic [7:0] f, input logic [7:0] d);
    apb(1'b1, 8'h00, f);
    apb(1'b1, 8'h08, 8'ha4);
    apb(1'b1, 8'h0c, d);
    apb(1'b0, 8'h10, 8'h00);
    apb(1'b1, 8'h10, 8'h7f);
  endtask
  task automatic tx_frames();
    logic [7:0] fmts [5] = '{8'h00, 8'h40, 8'h20, 8'h38, 8'h64};
    foreach (fmts[i])
    begin
      send_char(fmts[i], 8'hb5);
      repeat (224) @(posedge clock);
      chk(frame, frm(fmts[i], 8'hb5));
      chk({10'h0, txEndIrq, txEmptyIrq}, 12'h003);
      apb(1'b1, 8'h08, 8'h80);
      chk({11'h0, txEmptyIrq}, 12'h001);
      apb(1'b1, 8'h08, 8'h00);
      chk({11'h0, txEmptyIrq}, 12'h000);
    end
  endtask
  task automatic prescale_rates();
    for (int s = 0; s < 4; s++)
    begin
      send_char(s[7:0], 8'h02);
      n = 0;
      while (txd !== 1'b0) @(negedge clock);
      while (txd !== 1'b1) @(negedge clock);
      while (txd === 1'b1)
      begin
        n++;
        @(negedge clock);
      end
      chk(n[11:0], 12'd16 << (2 * s));
      repeat (8 * n) @(posedge clock);
      apb(1'b1, 8'h08, 8'h00);
    end
  endtask
  task automatic rx_flags();
    apb(1'b1, 8'h00, 8'h20);
    apb(1'b1, 8'h08, 8'h50);
    i_peer.send(frm(8'h20, 8'h3c));
    repeat (8) @(posedge clock);
    chk({11'h0, rxFullIrq}, 12'h001);
    apb(1'b0, 8'h14, 8'h00);
    chk(q, 12'h03c);
    apb(1'b0, 8'h10, 8'h00);
    apb(1'b1, 8'h10, 8'hbf);
    chk({11'h0, rxFullIrq}, 12'h000);
    i_peer.send(frm(8'h20, 8'h3c) ^ 12'h200);
    repeat (8) @(posedge clock);
    apb(1'b1, 8'h08, 8'h40);
    apb(1'b0, 8'h10, 8'h00);
    chk(q & 12'h148, 12'h008);
    chk({11'h0, rxErrIrq}, 12'h001);
    apb(1'b1, 8'h10, 8'hf7);
    chk({11'h0, rxErrIrq}, 12'h000);
  endtask
  task automatic regs_standby();
    apb(1'b0, 8'h08, 8'h00);
    chk(q, 12'h040);
    apb(1'b0, 8'h20, 8'h00);
    chk(q, 12'h100);
    apb(1'b1, 8'h00, 8'h5a);
    apb(1'b0, 8'h00, 8'h00);
    chk(q, 12'h05a);
    standby <= 1'b1;
    @(posedge clock);
    standby <= 1'b0;
    @(posedge clock);
    apb(1'b0, 8'h00, 8'h00);
    chk(q, 12'h000);
  endtask
  // Reset, then the scenarios and the verdict.
  initial
  begin
    rst_b = 1'b0;
    standby = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    apb(1'b1, 8'h04, 8'h00);
    tx_frames();
    prescale_rates();
    rx_flags();
    regs_standby();
    conclude();
  end
endmodule
`default_nettype wire
